// ==== include/aac_pkg.sv ====
package aac_pkg;

  // ****************************************
  // Register pointer codes
  // ****************************************
  localparam logic [2:0] AAC_PTR_RESULT   = 3'h0;
  localparam logic [2:0] AAC_PTR_STATUS   = 3'h1;
  localparam logic [2:0] AAC_PTR_CONTROL  = 3'h2;
  localparam logic [2:0] AAC_PTR_UNDER    = 3'h3;
  localparam logic [2:0] AAC_PTR_OVER     = 3'h4;
  localparam logic [2:0] AAC_PTR_HYST     = 3'h5;
  localparam logic [2:0] AAC_PTR_MINIMUM  = 3'h6;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int AAC_DATA_W      = 12;
  localparam int AAC_CYC_HI      = 7;
  localparam int AAC_CYC_LO      = 5;
  localparam int AAC_HOLD_BIT    = 4;
  localparam int AAC_FLAGEN_BIT  = 3;
  localparam int AAC_PINEN_BIT   = 2;
  localparam int AAC_POL_BIT     = 0;
  localparam int AAC_OVER_BIT    = 1;
  localparam int AAC_UNDER_BIT   = 0;
  localparam int AAC_ALERT_BIT   = 15;

  // Writable bits of the control byte; bit 1 is reserved
  localparam logic [7:0]  AAC_CTRL_MASK  = 8'hfd;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  AAC_CTRL_RST   = 8'h00;
  localparam logic [11:0] AAC_UNDER_RST  = 12'h000;
  localparam logic [11:0] AAC_OVER_RST   = 12'hfff;
  localparam logic [11:0] AAC_HYST_RST   = 12'h000;
  localparam logic [11:0] AAC_MIN_RST    = 12'hfff;

  // ****************************************
  // Timing
  // ****************************************
  localparam int AAC_CLK_MHZ       = 50;
  localparam int AAC_TCONV_NS      = 1000;
  localparam int AAC_TCONV_CYCLES  = (AAC_TCONV_NS * AAC_CLK_MHZ) / 1000;
  // Interval multiplier for code 1 is 32 = 1 << 5, doubling per code
  localparam int AAC_MULT_SHIFT0   = 4;

endpackage

// ==== core/aac_cycle_timer.sv ====
`timescale 1ns/1ps

module aac_cycle_timer
  import aac_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = AAC_TCONV_CYCLES
)
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] cycle_code_in,
  output logic            conv_start_out
);

  // ****************************************
  // Interval length per code
  // ****************************************
  function automatic logic [31:0] interval_len(input logic [2:0] code);
    logic [31:0] base;
    base = 32'(CONV_CYCLES);
    interval_len = base << (32'(code) + 32'(AAC_MULT_SHIFT0));
  endfunction

  logic [31:0] count;
  logic [31:0] limit;

  assign limit = interval_len(cycle_code_in);

  // Counter restarts while mode is off so the first interval is full
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count          <= '0;
      conv_start_out <= 1'b0;
    end
    else if (cycle_code_in == 3'h0)
    begin
      count          <= '0;
      conv_start_out <= 1'b0;
    end
    else if (count >= limit - 32'h1)
    begin
      count          <= '0;
      conv_start_out <= 1'b1;
    end
    else
    begin
      count          <= count + 32'h1;
      conv_start_out <= 1'b0;
    end
  end

endmodule

// ==== core/aac_regs.sv ====
`timescale 1ns/1ps

// How it works
// - Cycle-time field zero keeps automatic conversions off; reset value is zero.
// - Non-zero code starts periodic conversions at 32..2048 conversion periods.
// - Hold bit clear: alert self-clears once result is back beyond hysteresis.
// - Hold bit set: alert flags clear only by writing one to them.
// - Control bit 3 gates the alert indicator in result word bit 15.
// - Control bit 2 enables the alert pin; disabled pin is released.
// - Control bit 0 picks pin polarity: zero active low, one active high.
// - Reserved bits read zero; writes to them are dropped.
// - Result below under-range limit raises the under-range flag.
// - Result above over-range limit raises the over-range flag.
// - Flag persists until result clears the limit by more than hysteresis.
// - Smaller result replaces the lowest-conversion value; others leave it.
// - Writing all ones to the lowest-conversion register restarts tracking.
// - Lowest value is compared on every conversion without host access.
// - Writing one to a status flag bit clears it; bit1 over, bit0 under.
// - Result bit 15 is OR of both flags when enabled, else zero.
module aac_regs
  import aac_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = AAC_TCONV_CYCLES
)
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [2:0]  reg_ptr_in,
  input  wire logic        reg_wr_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic        conv_valid_in,
  input  wire logic [11:0] conv_data_in,
  output logic             conv_start_out,
  output logic             alert_out,
  output logic             alert_oe_out
);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]  control_settings;
  logic [11:0] under_range_threshold;
  logic [11:0] over_range_threshold;
  logic [11:0] alert_hysteresis;
  logic [11:0] minimum_result_tracker;
  logic [11:0] last_result;
  logic        over_flag;
  logic        under_flag;

  logic        wr_ctrl;
  logic        wr_under;
  logic        wr_over;
  logic        wr_hyst;
  logic        wr_min;
  logic        wr_stat;
  logic        over_hit;
  logic        under_hit;
  logic        over_release;
  logic        under_release;
  logic        hold;
  logic        flag_any;
  logic [15:0] next_rdata;

  // Strobe and pointer are arguments so each assign tracks them
  function automatic logic hit(input logic       wr,
                               input logic [2:0] ptr,
                               input logic [2:0] p);
    hit = wr && (ptr == p);
  endfunction

  assign wr_ctrl  = hit(reg_wr_in, reg_ptr_in, AAC_PTR_CONTROL);
  assign wr_under = hit(reg_wr_in, reg_ptr_in, AAC_PTR_UNDER);
  assign wr_over  = hit(reg_wr_in, reg_ptr_in, AAC_PTR_OVER);
  assign wr_hyst  = hit(reg_wr_in, reg_ptr_in, AAC_PTR_HYST);
  assign wr_min   = hit(reg_wr_in, reg_ptr_in, AAC_PTR_MINIMUM);
  assign wr_stat  = hit(reg_wr_in, reg_ptr_in, AAC_PTR_STATUS);
  assign hold     = control_settings[AAC_HOLD_BIT];
  assign flag_any = over_flag | under_flag;

  // ****************************************
  // Window comparison
  // ****************************************
  assign over_hit  = conv_valid_in
                     && (conv_data_in > over_range_threshold);
  assign under_hit = conv_valid_in
                     && (conv_data_in < under_range_threshold);
  // 13-bit sums avoid wrap when limit and hysteresis are large
  assign over_release = conv_valid_in && !hold
    && ({1'b0, conv_data_in} + {1'b0, alert_hysteresis}
        < {1'b0, over_range_threshold});
  assign under_release = conv_valid_in && !hold
    && ({1'b0, conv_data_in}
        > {1'b0, under_range_threshold} + {1'b0, alert_hysteresis});

  // ****************************************
  // Host-written registers
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      control_settings      <= AAC_CTRL_RST;
      under_range_threshold <= AAC_UNDER_RST;
      over_range_threshold  <= AAC_OVER_RST;
      alert_hysteresis      <= AAC_HYST_RST;
    end
    else
    begin
      if (wr_ctrl)
        control_settings <= reg_wdata_in[7:0] & AAC_CTRL_MASK;
      if (wr_under)
        under_range_threshold <= reg_wdata_in[AAC_DATA_W-1:0];
      if (wr_over)
        over_range_threshold <= reg_wdata_in[AAC_DATA_W-1:0];
      if (wr_hyst)
        alert_hysteresis <= reg_wdata_in[AAC_DATA_W-1:0];
    end
  end

  // ****************************************
  // Alert flags: a new violation beats a clear
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      over_flag <= 1'b0;
    else if (over_hit)
      over_flag <= 1'b1;
    else if (wr_stat && reg_wdata_in[AAC_OVER_BIT])
      over_flag <= 1'b0;
    else if (over_release)
      over_flag <= 1'b0;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      under_flag <= 1'b0;
    else if (under_hit)
      under_flag <= 1'b1;
    else if (wr_stat && reg_wdata_in[AAC_UNDER_BIT])
      under_flag <= 1'b0;
    else if (under_release)
      under_flag <= 1'b0;
  end

  // ****************************************
  // Result capture and minimum tracking
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      last_result <= '0;
    else if (conv_valid_in)
      last_result <= conv_data_in;
  end

  // Host write wins over a same-cycle conversion so a restart sticks
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      minimum_result_tracker <= AAC_MIN_RST;
    else if (wr_min)
      minimum_result_tracker <= reg_wdata_in[AAC_DATA_W-1:0];
    else if (conv_valid_in && conv_data_in < minimum_result_tracker)
      minimum_result_tracker <= conv_data_in;
  end

  // ****************************************
  // Automatic conversion timer
  // ****************************************
  aac_cycle_timer #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_timer (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .cycle_code_in  (control_settings[AAC_CYC_HI:AAC_CYC_LO]),
    .conv_start_out (conv_start_out)
  );

  // ****************************************
  // Read mux, registered
  // ****************************************
  always_comb
  begin
    next_rdata = 16'h0000;
    case (reg_ptr_in)
      AAC_PTR_RESULT:
      begin
        next_rdata[AAC_DATA_W-1:0] = last_result;
        next_rdata[AAC_ALERT_BIT]  = control_settings[AAC_FLAGEN_BIT]
                                     & flag_any;
      end
      AAC_PTR_STATUS:
      begin
        next_rdata[AAC_OVER_BIT]  = over_flag;
        next_rdata[AAC_UNDER_BIT] = under_flag;
      end
      AAC_PTR_CONTROL: next_rdata[7:0] = control_settings;
      AAC_PTR_UNDER:   next_rdata[AAC_DATA_W-1:0] = under_range_threshold;
      AAC_PTR_OVER:    next_rdata[AAC_DATA_W-1:0] = over_range_threshold;
      AAC_PTR_HYST:    next_rdata[AAC_DATA_W-1:0] = alert_hysteresis;
      AAC_PTR_MINIMUM: next_rdata[AAC_DATA_W-1:0] = minimum_result_tracker;
      default:         next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      reg_rdata_out <= 16'h0000;
    else
      reg_rdata_out <= next_rdata;
  end

  // ****************************************
  // Alert pin
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      alert_oe_out <= 1'b0;
      alert_out    <= 1'b1;
    end
    else
    begin
      alert_oe_out <= control_settings[AAC_PINEN_BIT];
      // Active level equals the polarity bit, idle level its inverse
      alert_out    <= ~(flag_any ^ control_settings[AAC_POL_BIT]);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_over_viol;
    conv_valid_in && conv_data_in > over_range_threshold;
  endsequence

  sequence s_under_viol;
    conv_valid_in && conv_data_in < under_range_threshold;
  endsequence

  sequence s_over_wr1;
    wr_stat && reg_wdata_in[AAC_OVER_BIT] && !over_hit;
  endsequence

  a_auto_off_idle: assert property (
    (control_settings[AAC_CYC_HI:AAC_CYC_LO] == 3'h0) [*2]
      |-> !conv_start_out)
    else $error("conversion started with mode off");

  a_over_set_flag: assert property (s_over_viol |=> over_flag)
    else $error("over-range flag not set");

  a_under_set_flag: assert property (s_under_viol |=> under_flag)
    else $error("under-range flag not set");

  a_hold_keeps_flag: assert property (
    hold && over_flag && !wr_ctrl
      && !(wr_stat && reg_wdata_in[AAC_OVER_BIT]) |=> over_flag)
    else $error("held alert cleared itself");

  a_self_clear_over: assert property (
    over_release && !(wr_stat && reg_wdata_in[AAC_OVER_BIT])
      |=> !over_flag)
    else $error("over-range flag failed to self-clear");

  a_inside_keeps: assert property (
    over_flag && conv_valid_in && !wr_stat
      && ({1'b0, conv_data_in} + {1'b0, alert_hysteresis}
          >= {1'b0, over_range_threshold}) |=> over_flag)
    else $error("over-range flag cleared inside hysteresis");

  a_status_w1c: assert property (
    wr_stat && reg_wdata_in[AAC_UNDER_BIT] && !under_hit |=> !under_flag)
    else $error("under-range flag not cleared by write");

  a_min_tracks: assert property (
    conv_valid_in && !wr_min && conv_data_in < minimum_result_tracker
      |=> minimum_result_tracker == $past(conv_data_in))
    else $error("lowest value not updated");

  a_pin_level: assert property (
    ##1 alert_out
      == ~($past(flag_any) ^ $past(control_settings[AAC_POL_BIT])))
    else $error("alert pin level wrong");

  a_pin_enable: assert property (
    control_settings[AAC_PINEN_BIT] ##1 control_settings[AAC_PINEN_BIT]
      |-> alert_oe_out)
    else $error("alert pin not driven while enabled");

  a_rsvd_zero: assert property (
    reg_ptr_in != AAC_PTR_RESULT |=> reg_rdata_out[15:12] == 4'h0)
    else $error("reserved bits read non-zero");

  a_over_w1c: assert property (s_over_wr1 |=> !over_flag)
    else $error("over-range flag not cleared by write");

  a_under_self_clr: assert property (
    under_release && !(wr_stat && reg_wdata_in[AAC_UNDER_BIT])
      |=> !under_flag)
    else $error("under-range flag failed to self-clear");

  a_under_hold: assert property (
    hold && under_flag && !wr_ctrl
      && !(wr_stat && reg_wdata_in[AAC_UNDER_BIT]) |=> under_flag)
    else $error("held under-range alert cleared itself");

  a_under_inside: assert property (
    under_flag && conv_valid_in && !wr_stat
      && ({1'b0, conv_data_in}
          <= {1'b0, under_range_threshold} + {1'b0, alert_hysteresis})
      |=> under_flag)
    else $error("under-range flag cleared inside hysteresis");

  a_min_keeps: assert property (
    conv_valid_in && !wr_min && conv_data_in >= minimum_result_tracker
      |=> $stable(minimum_result_tracker))
    else $error("lowest value changed by a larger result");

  a_min_restart: assert property (
    wr_min
      |=> minimum_result_tracker == $past(reg_wdata_in[AAC_DATA_W-1:0]))
    else $error("lowest value restart not taken");

  a_alert_bit15: assert property (
    reg_ptr_in == AAC_PTR_RESULT
      |=> reg_rdata_out[AAC_ALERT_BIT]
          == $past(control_settings[AAC_FLAGEN_BIT] & flag_any))
    else $error("result alert bit wrong");

  a_pin_off: assert property (
    !control_settings[AAC_PINEN_BIT] |=> !alert_oe_out)
    else $error("alert pin driven while disabled");

  a_start_pulse: assert property (conv_start_out |=> !conv_start_out)
    else $error("conversion request longer than one cycle");

endmodule

// ==== verification/aac_conv_model.sv ====
`timescale 1ns/1ps

// ****************************************
// Converter stand-in: answers each request one cycle later
// ****************************************
module aac_conv_model
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        start_in,
  input  wire logic        req_in,
  input  wire logic [11:0] sample_in,
  output logic             conv_valid_out,
  output logic      [11:0] conv_data_out
);
  // Data is inverted on each cycle outside a valid one, so a stale value matches again every second cycle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      conv_valid_out <= 1'b0;
      conv_data_out  <= 12'h000;
    end
    else
    begin
      conv_valid_out <= start_in | req_in;
      conv_data_out  <= (start_in | req_in) ? sample_in : ~conv_data_out;
    end
  end
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  end end

module tb_top;
  import aac_pkg::*;

  logic        clk_in       = 1'b0;
  logic        rst_in       = 1'b1;
  logic [2:0]  reg_ptr_in   = 3'h0;
  logic        reg_wr_in    = 1'b0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic [15:0] reg_rdata_out;
  logic        conv_valid_in;
  logic [11:0] conv_data_in;
  logic        conv_start_out;
  logic        alert_out;
  logic        alert_oe_out;
  logic        req_in       = 1'b0;
  logic [11:0] sample_in    = 12'h000;
  int          n_mismatch   = 0;
  int          num_checks   = 0;
  int          cycles       = 0;

  always #10 clk_in = ~clk_in;

  aac_regs #(.CONV_CYCLES(1)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .reg_ptr_in(reg_ptr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .conv_valid_in(conv_valid_in),
    .conv_data_in(conv_data_in), .conv_start_out(conv_start_out),
    .alert_out(alert_out), .alert_oe_out(alert_oe_out));

  aac_conv_model i_conv (
    .clk_in(clk_in), .rst_in(rst_in), .start_in(conv_start_out),
    .req_in(req_in), .sample_in(sample_in),
    .conv_valid_out(conv_valid_in), .conv_data_out(conv_data_in));

  // ****************************************
  // Bus and conversion helpers
  // ****************************************
  // Idle cycle after each write keeps the strobe a clean pulse
  task automatic wr(input logic [2:0] p, input logic [15:0] d);
    reg_ptr_in = p;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(posedge clk_in); #1;
    reg_wr_in = 1'b0;
    @(posedge clk_in); #1;
  endtask

  task automatic chk_reg(input logic [2:0] p, input logic [15:0] e);
    reg_ptr_in = p;
    @(posedge clk_in); #1;
    `CHK("register", e, reg_rdata_out)
  endtask

  task automatic conv(input logic [11:0] v);
    sample_in = v;
    req_in = 1'b1;
    @(posedge clk_in); #1;
    req_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_defaults();
    logic [15:0] exp_v [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0fff,
                               16'h0, 16'h0fff};
    for (int p = 0; p < 7; p++)
      chk_reg(3'(p), exp_v[p]);
    `CHK("pin enable", 1'b0, alert_oe_out)
  endtask

  // Host keeps reserved bits zero; only mapped bits carry ones
  task automatic t_reserved();
    wr(3'h2, 16'h00fd);
    chk_reg(3'h2, 16'h00fd);
    wr(3'h2, 16'h0000);
    wr(3'h0, 16'h0fff);
    wr(3'h7, 16'h0fff);
    chk_reg(3'h0, 16'h0000);
    for (int p = 3; p < 7; p++)
    begin
      wr(3'(p), 16'h0fff);
      chk_reg(3'(p), 16'h0fff);
    end
    wr(3'h3, 16'h0000);
    wr(3'h5, 16'h0000);
  endtask

  // Interval in clock cycles is 16 << code with one-cycle periods
  task automatic t_timer();
    int n;
    wr(3'h6, 16'h0fff);
    sample_in = 12'h123;
    for (int k = 1; k < 8; k++)
    begin
      wr(3'h2, 16'(k << 5));
      n = 0;
      while (conv_start_out !== 1'b1 && n < 3000)
      begin
        @(posedge clk_in); #1;
        n++;
      end
      n = 0;
      do
      begin
        @(posedge clk_in); #1;
        n++;
      end while (conv_start_out !== 1'b1 && n < 3000);
      `CHK("interval", 16 << k, n)
    end
    wr(3'h2, 16'h0000);
    chk_reg(3'h6, 16'h0123);
    n = 0;
    repeat (80)
    begin
      @(posedge clk_in); #1;
      if (conv_start_out !== 1'b0)
        n++;
    end
    `CHK("idle pulses", 0, n)
  endtask

  task automatic t_alert();
    wr(3'h3, 16'h0100);
    wr(3'h4, 16'h0800);
    wr(3'h5, 16'h0010);
    wr(3'h2, 16'h000d);
    conv(12'h900);
    chk_reg(3'h1, 16'h0002);
    chk_reg(3'h0, 16'h8900);
    `CHK("alert level", 1'b1, alert_out)
    `CHK("pin enable", 1'b1, alert_oe_out)
    conv(12'h7f5);
    chk_reg(3'h1, 16'h0002);
    conv(12'h7ef);
    chk_reg(3'h1, 16'h0000);
    `CHK("alert level", 1'b0, alert_out)
    conv(12'h0ff);
    chk_reg(3'h1, 16'h0001);
    wr(3'h2, 16'h001d);
    conv(12'h200);
    chk_reg(3'h1, 16'h0001);
    wr(3'h2, 16'h000c);
    `CHK("alert level", 1'b0, alert_out)
    wr(3'h2, 16'h0004);
    chk_reg(3'h0, 16'h0200);
    wr(3'h2, 16'h0008);
    `CHK("pin enable", 1'b0, alert_oe_out)
    wr(3'h1, 16'h0001);
    chk_reg(3'h1, 16'h0000);
  endtask

  // Violation and clear meet on one edge in the middle: the set must win
  task automatic t_clear();
    wr(3'h2, 16'h0010);
    conv(12'h900);
    conv(12'h100);
    chk_reg(3'h1, 16'h0002);
    wr(3'h1, 16'h0002);
    chk_reg(3'h1, 16'h0000);
    sample_in = 12'h900;
    req_in = 1'b1;
    @(posedge clk_in); #1;
    req_in = 1'b0;
    wr(3'h1, 16'h0002);
    chk_reg(3'h1, 16'h0002);
    wr(3'h1, 16'h0002);
    wr(3'h2, 16'h0000);
    conv(12'h050);
    conv(12'h110);
    chk_reg(3'h1, 16'h0001);
    conv(12'h121);
    chk_reg(3'h1, 16'h0000);
  endtask

  // A reset in mid-run must bring back every default
  task automatic t_reset();
    wr(3'h4, 16'h0123);
    wr(3'h2, 16'h00e5);
    rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    t_defaults();
  endtask

  task automatic t_minimum();
    wr(3'h6, 16'h0fff);
    chk_reg(3'h6, 16'h0fff);
    conv(12'h300);
    chk_reg(3'h6, 16'h0300);
    conv(12'h400);
    chk_reg(3'h6, 16'h0300);
    conv(12'h300);
    chk_reg(3'h6, 16'h0300);
  endtask

  // ****************************************
  // Verdict
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Ceiling covers the longest timer sweep with margin
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    t_defaults();
    t_reserved();
    t_timer();
    t_alert();
    t_clear();
    t_minimum();
    t_reset();
    tally_and_finish();
  end
endmodule
